// ===== dsq_pkg.sv
// Purpose: constants and types shared by the display rail sequencer files.
// Assumes: a 20 MHz system clock; pins and analog flags arrive asynchronously.
// Notes:   rail delay, base timeout and temperature interval here are only defaults; the top exposes them as parameters.
// Function
// RQ1: rails follow select edges, host sets timing
// RQ2: rails regulate 2 ms, first 6 ms
// RQ3: select bits map to four fixed rails
// RQ4: all selects low, rails off: standby
// RQ5: wake low while active: power-down, sleep
// RQ6: boost enable gated by inverter power-good
// RQ7: source, bias, pumps gated by boost good
// RQ8: positive source gated by negative source good
// RQ9: host spaces select rises over 62.5 us
// RQ10: close rises stagger rails in fixed order
// RQ11: two selects falling together drop all
// RQ12: base converters not good in 10 ms
// RQ13: global fault: pin low, power-down, standby
// RQ14: rail undervoltage drops rail and dependents
// RQ15: selects act on edges; re-toggle after fault
// RQ16: ok pin released only when all regulate
// RQ17: temperature refreshed every 60 s
// RQ18: 10-bit conversion mapped to temperature code
// RQ19: signed code, saturating at F6 and 55
// RQ20: wake low sleeps, wake high standby
// RQ21: temperature code held stable between refreshes
package dsq_pkg;
   // =======================================================
   // clock and times
   localparam int CLK_MHZ      = 20;
   localparam int RAIL_DLY_US  = 2000;
   localparam int FIRST_DLY_US = 6000;
   localparam int BASE_TMO_US  = 10000;
   localparam int GAP_NS       = 62500;
   localparam int TEMP_IVL_S   = 60;
   localparam int RAIL_DLY_CYC = RAIL_DLY_US * CLK_MHZ;
   localparam int FIRST_DLY_CYC = FIRST_DLY_US * CLK_MHZ;
   localparam int BASE_TMO_CYC = BASE_TMO_US * CLK_MHZ;
   localparam int GAP_CYC      = (GAP_NS * CLK_MHZ + 999) / 1000;
   localparam int TEMP_IVL_CYC = TEMP_IVL_S * CLK_MHZ * 1000000;
   // =======================================================
   // synchronised pin vector positions
   localparam int P_SEL   = 0;
   localparam int P_WAKE  = 4;
   localparam int P_BPG   = 5;
   localparam int P_IPG   = 6;
   localparam int P_RPG   = 7;
   localparam int P_RUV   = 11;
   localparam int P_TRIP  = 15;
   localparam int P_LOCK  = 16;
   localparam int P_BUV   = 17;
   localparam int P_IUV   = 18;
   localparam int PIN_W   = 19;
   // =======================================================
   // register offsets and reset values
   localparam logic [3:0] REG_TEMP   = 4'h0;
   localparam logic [3:0] REG_STAT   = 4'h1;
   localparam logic [3:0] REG_RAILS  = 4'h2;
   localparam logic [3:0] REG_CTRL   = 4'h3;
   localparam logic [7:0] CTRL_RST   = 8'h01;
   localparam int         CTRL_RUN   = 0;
   localparam int         CTRL_NOW   = 1;
   // =======================================================
   // temperature mapping
   localparam int         ADC_W      = 10;
   localparam logic [9:0] ADC_ZERO   = 10'h062;
   localparam logic [7:0] CODE_MIN   = 8'hF6;
   localparam logic [7:0] CODE_MAX   = 8'h55;
   localparam logic [7:0] CODE_RST   = 8'h00;
   // =======================================================
   // operating modes
   typedef enum logic [1:0] {M_SLEEP, M_STANDBY, M_ACTIVE, M_PWRDN} dsq_mode_t;
endpackage : dsq_pkg

// ===== dsq_temp_if.sv
// Purpose: links the sequencer top to its temperature converter.
// Assumes: both ends on sys_clk_in.
// Notes:   adc_done is a one-cycle pulse with adc_raw valid beside it.
interface dsq_temp_if;
   logic       run;
   logic       refresh;
   logic       adc_start;
   logic       adc_done;
   logic [9:0] adc_raw;
   logic [7:0] code;
   logic       busy;
   modport seq (output run, refresh, adc_done, adc_raw,
                input adc_start, code, busy);
   modport tmp (input run, refresh, adc_done, adc_raw,
                output adc_start, code, busy);
endinterface : dsq_temp_if

// ===== dsq_temp_conv.sv
// Purpose: periodic thermistor conversion and temperature code holding.
// Assumes: converter answers each start with one adc_done pulse.
// Notes:   code changes only on adc_done, so reads never see a torn value.
module dsq_temp_conv #(
   parameter int IVL_CYC = dsq_pkg::TEMP_IVL_CYC
) (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic reset_in,
   // sequencer side
   dsq_temp_if.tmp   t
);
   localparam int IW = $clog2(IVL_CYC + 1);
   typedef enum logic {T_IDLE, T_WAIT} dsq_tstate_t;
   typedef struct packed {
      dsq_tstate_t   st;
      logic [IW-1:0] tmr;
      logic          start;
      logic [7:0]    code;
   } dsq_tconv_t;
   dsq_tconv_t r;
   dsq_tconv_t next_r;
   logic signed [11:0] deg;

   // =======================================================
   // mapping: one count per degree around the zero point
   assign deg = $signed({2'b00, dsq_pkg::ADC_ZERO}) - $signed({2'b00, t.adc_raw}); // RQ18

   always_comb begin
      next_r = r;
      next_r.start = 1'b0;
      case (r.st)
         T_IDLE: begin
            // timer parked at zero while stopped, so a restart converts at once
            if (!t.run) begin
               next_r.tmr = '0;
            end else if (t.refresh || r.tmr == '0) begin
               next_r.start = 1'b1;
               next_r.st    = T_WAIT;
               next_r.tmr   = IW'(IVL_CYC - 1); // RQ17
            end else begin
               next_r.tmr = r.tmr - 1'b1;
            end
         end
         T_WAIT: begin
            if (r.tmr != '0) begin
               next_r.tmr = r.tmr - 1'b1;
            end
            if (t.adc_done) begin
               next_r.st = T_IDLE;
               if (deg < -12'sd10) begin
                  next_r.code = dsq_pkg::CODE_MIN; // RQ19
               end else if (deg > 12'sd85) begin
                  next_r.code = dsq_pkg::CODE_MAX; // RQ19
               end else begin
                  next_r.code = deg[7:0]; // RQ21
               end
            end else if (!t.run) begin
               next_r.st = T_IDLE;
            end
         end
         default: begin
            next_r.st = T_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         r <= '{st: T_IDLE, tmr: '0, start: 1'b0, code: dsq_pkg::CODE_RST};
      end else begin
         r <= next_r;
      end
   end

   assign t.adc_start = r.start;
   assign t.code      = r.code;
   assign t.busy      = (r.st == T_WAIT);

   // =======================================================
   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   code_sat_a: assert property (r.st == T_WAIT && t.adc_done && deg < -12'sd10
      |=> r.code == 8'hF6) else $error("cold code not saturated"); // RQ19
   code_hold_a: assert property (!(r.st == T_WAIT && t.adc_done)
      |=> $stable(r.code)) else $error("code moved between refreshes"); // RQ21
endmodule : dsq_temp_conv

// ===== dsq_seq.sv
// Purpose: rail ordering, gating and fault handling for the display rails.
// Assumes: pins and analog flags are asynchronous; converter is on sys_clk_in.
// Notes:   regulation delay is analog; this logic only gates the enables.
//
// The address map and the address-and-strobe port were left to the implementer.
module dsq_seq #(
   parameter int RAIL_DLY = dsq_pkg::RAIL_DLY_CYC,
   parameter int BASE_TMO = dsq_pkg::BASE_TMO_CYC,
   parameter int TEMP_IVL = dsq_pkg::TEMP_IVL_CYC
) (
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       reset_in,
   // host pins
   input  wire logic [3:0] rail_select_in,
   input  wire logic       wake_request_in,
   // analog status
   input  wire logic       boost_pg_in,
   input  wire logic       inverter_pg_in,
   input  wire logic [3:0] rail_pg_in,
   input  wire logic [3:0] rail_uv_in,
   input  wire logic       thermal_trip_in,
   input  wire logic       input_supply_lockout_in,
   input  wire logic       boost_undervoltage_in,
   input  wire logic       inverter_undervoltage_in,
   // converter enables
   output logic            boost_en_out,
   output logic            inverter_en_out,
   output logic [3:0]      rail_en_out,
   output logic            backplane_bias_en_out,
   // open-drain ok pin
   output logic            rails_ok_out,
   output logic            rails_ok_oe_out,
   // thermistor converter
   output logic            adc_start_out,
   input  wire logic       adc_done_in,
   input  wire logic [9:0] adc_raw_in,
   // register port
   input  wire logic [3:0] bus_addr_in,
   input  wire logic [7:0] bus_wdata_in,
   input  wire logic       bus_wr_in,
   input  wire logic       bus_rd_in,
   output logic [7:0]      bus_rdata_out,
   output logic [7:0]      temperature_code_out
);
   localparam int TW = $clog2((RAIL_DLY > BASE_TMO ? RAIL_DLY : BASE_TMO) + 1);
   localparam int GW = $clog2(dsq_pkg::GAP_CYC + 1);

   typedef struct packed {
      dsq_pkg::dsq_mode_t       mode;
      dsq_pkg::dsq_mode_t       tgt;
      logic [dsq_pkg::PIN_W-1:0] s1;
      logic [dsq_pkg::PIN_W-1:0] s2;
      logic [4:0]               s3;
      logic [3:0]               req;
      logic [3:0]               allow;
      logic                     base;
      logic                     stag;
      logic [TW-1:0]            tmr;
      logic [GW-1:0]            gap;
      logic [1:0]               pd_idx;
      logic [7:0]               rdata;
      logic [7:0]               ctrl;
      logic                     now;
      logic                     pfall;
   } dsq_seq_t;

   dsq_seq_t   r;
   dsq_seq_t   next_r;
   logic [3:0] sel;
   logic [3:0] rise;
   logic [3:0] fall;
   logic       wake;
   logic       bpg;
   logic       ipg;
   logic [3:0] pg;
   logic [3:0] uv;
   logic       gfault;
   logic       base_ok;
   logic       close;
   logic [3:0] gate;
   logic [3:0] en;
   logic       all_ok;
   logic [3:0] kill;
   dsq_temp_if ti ();

   // =======================================================
   // synchronised views; first stage feeds only the second
   assign sel    = r.s2[dsq_pkg::P_SEL +: 4];
   assign wake   = r.s2[dsq_pkg::P_WAKE];
   assign bpg    = r.s2[dsq_pkg::P_BPG];
   assign ipg    = r.s2[dsq_pkg::P_IPG];
   assign pg     = r.s2[dsq_pkg::P_RPG +: 4];
   assign uv     = r.s2[dsq_pkg::P_RUV +: 4];
   assign rise   = sel & ~r.s3[3:0]; // RQ15
   assign fall   = ~sel & r.s3[3:0]; // RQ15
   assign gfault = r.s2[dsq_pkg::P_TRIP] | r.s2[dsq_pkg::P_LOCK]
                 | r.s2[dsq_pkg::P_BUV] | r.s2[dsq_pkg::P_IUV];
   assign base_ok = bpg & ipg;
   assign close  = (r.gap < GW'(dsq_pkg::GAP_CYC));

   // =======================================================
   // enable gating: each rail waits on the good of what it depends on
   // bit 0 negative source plus bias, 1 negative pump, 2 positive source,
   // 3 positive pump
   assign gate[0] = bpg; // RQ7
   assign gate[1] = bpg & (~r.stag | ~r.req[0] | pg[0]); // RQ10
   assign gate[2] = bpg & pg[0] & (~r.stag | ~r.req[1] | pg[1]); // RQ8
   assign gate[3] = bpg & (~r.stag | ~r.req[2] | pg[2]); // RQ10
   assign en      = r.req & r.allow & gate; // RQ3
   assign all_ok  = (&en) & (&pg) & ~(|uv) & (r.mode == dsq_pkg::M_ACTIVE);

   // =======================================================
   // undervoltage on a rail drops it and whatever stands on it
   always_comb begin
      kill = uv & en; // RQ14
      if (kill[0]) begin
         kill[2] = 1'b1;
      end
      if (r.stag) begin
         for (int i = 1; i < 4; i++) begin
            kill[i] = kill[i] | kill[i-1];
         end
      end
   end

   // =======================================================
   // mode sequencing
   always_comb begin
      next_r = r;
      next_r.s1 = {inverter_undervoltage_in, boost_undervoltage_in,
                   input_supply_lockout_in, thermal_trip_in, rail_uv_in,
                   rail_pg_in, inverter_pg_in, boost_pg_in, wake_request_in,
                   rail_select_in};
      next_r.s2 = r.s1;
      next_r.s3 = r.s2[4:0];
      next_r.now = 1'b0;
      // edge spacing watch, saturating so it never wraps
      if (|rise || |fall) begin
         next_r.gap = '0;
         next_r.pfall = |fall;
      end else if (close) begin
         next_r.gap = r.gap + 1'b1;
      end
      case (r.mode)
         dsq_pkg::M_SLEEP: begin
            next_r.req   = '0;
            next_r.allow = '0;
            next_r.base  = 1'b0;
            if (wake) begin // RQ20
               next_r.allow = 4'hF;
               next_r.tmr   = '0;
               next_r.stag  = 1'b1;
               if (|sel && !gfault) begin
                  // levels present at wake start the fixed order
                  next_r.req  = sel;
                  next_r.base = 1'b1; // RQ2
                  next_r.mode = dsq_pkg::M_ACTIVE;
               end else begin
                  next_r.mode = dsq_pkg::M_STANDBY;
               end
            end
         end
         dsq_pkg::M_STANDBY: begin
            next_r.req  = '0;
            next_r.base = 1'b0;
            if (!wake) begin
               next_r.mode = dsq_pkg::M_SLEEP; // RQ4
            end else if (|rise && !gfault) begin
               // first rail waits on both base converters starting
               next_r.req   = rise; // RQ1
               next_r.base  = 1'b1; // RQ2
               next_r.allow = 4'hF;
               next_r.tmr   = '0;
               next_r.stag  = ($countones(rise) > 1); // RQ10
               next_r.mode  = dsq_pkg::M_ACTIVE;
            end
         end
         dsq_pkg::M_ACTIVE: begin
            next_r.req = (r.req | rise) & ~fall & ~kill; // RQ1
            if (|rise && close && !r.pfall) begin
               next_r.stag = 1'b1; // RQ10
            end
            if ($countones(fall) > 1 || (|fall && close && r.pfall)) begin
               next_r.req = '0; // RQ11
            end
            // base watchdog only runs while a converter is not good
            if (base_ok) begin
               next_r.tmr = '0;
            end else begin
               next_r.tmr = r.tmr + 1'b1;
            end
            if (gfault) begin
               next_r.mode   = dsq_pkg::M_PWRDN; // RQ13
               next_r.tgt    = dsq_pkg::M_STANDBY;
               next_r.tmr    = '0;
               next_r.pd_idx = 2'd3;
            end else if (!base_ok && r.tmr == TW'(BASE_TMO - 1)) begin
               next_r.mode   = dsq_pkg::M_PWRDN; // RQ12
               next_r.tgt    = dsq_pkg::M_STANDBY;
               next_r.tmr    = '0;
               next_r.pd_idx = 2'd3;
            end else if (!wake) begin
               next_r.mode   = dsq_pkg::M_PWRDN; // RQ5
               next_r.tgt    = dsq_pkg::M_SLEEP;
               next_r.tmr    = '0;
               next_r.pd_idx = 2'd3;
            end else if (next_r.req == '0 && en == '0) begin
               next_r.base = 1'b0; // RQ4
               next_r.stag = 1'b0;
               next_r.mode = dsq_pkg::M_STANDBY;
            end
         end
         dsq_pkg::M_PWRDN: begin
            // fixed order: positive pump, positive source, negative pump,
            // negative source; inputs are ignored until it ends
            if (r.tmr == TW'(RAIL_DLY - 1)) begin
               next_r.tmr = '0;
               next_r.allow[r.pd_idx] = 1'b0;
               next_r.pd_idx = r.pd_idx - 1'b1;
               if (r.pd_idx == 2'd0) begin
                  next_r.req  = '0;
                  next_r.base = 1'b0;
                  next_r.stag = 1'b0;
                  next_r.mode = r.tgt;
               end
            end else begin
               next_r.tmr = r.tmr + 1'b1;
            end
         end
         default: begin
            next_r.mode = dsq_pkg::M_STANDBY;
         end
      endcase
      // register port: read data stand the cycle after the strobe only
      next_r.rdata = '0;
      if (bus_rd_in) begin
         case (bus_addr_in)
            dsq_pkg::REG_TEMP:  next_r.rdata = ti.code;
            dsq_pkg::REG_STAT:  next_r.rdata = {ti.busy, gfault, r.stag,
                                                r.base, all_ok, base_ok,
                                                r.mode};
            dsq_pkg::REG_RAILS: next_r.rdata = {pg, en};
            dsq_pkg::REG_CTRL:  next_r.rdata = r.ctrl;
            default:            next_r.rdata = '0;
         endcase
      end
      if (bus_wr_in && bus_addr_in == dsq_pkg::REG_CTRL) begin
         next_r.ctrl = {7'h00, bus_wdata_in[dsq_pkg::CTRL_RUN]};
         next_r.now  = bus_wdata_in[dsq_pkg::CTRL_NOW];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         r <= '{mode: dsq_pkg::M_SLEEP, tgt: dsq_pkg::M_STANDBY,
                ctrl: dsq_pkg::CTRL_RST, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // =======================================================
   // outputs; base converters follow the base flag, boost after inverter
   assign inverter_en_out       = r.base;
   assign boost_en_out          = r.base & ipg; // RQ6
   assign rail_en_out           = en;
   assign backplane_bias_en_out = en[0]; // RQ3
   assign rails_ok_out          = 1'b0;
   assign rails_ok_oe_out       = ~all_ok; // RQ16
   assign bus_rdata_out         = r.rdata;

   // =======================================================
   // temperature path; halted in sleep since everything is off there
   assign ti.run        = (r.mode != dsq_pkg::M_SLEEP) & r.ctrl[dsq_pkg::CTRL_RUN];
   assign ti.refresh    = r.now;
   assign ti.adc_done   = adc_done_in;
   assign ti.adc_raw    = adc_raw_in;
   assign adc_start_out = ti.adc_start;
   assign temperature_code_out = ti.code;

   dsq_temp_conv #(.IVL_CYC(TEMP_IVL)) u_temp (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .t          (ti.tmp)
   );

   // =======================================================
   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   boost_gate_a: assert property (boost_en_out |-> ipg && inverter_en_out)
      else $error("boost enabled before inverter good"); // RQ6
   negsrc_gate_a: assert property (rail_en_out[0] |-> bpg)
      else $error("negative source enabled without boost good"); // RQ7
   possrc_gate_a: assert property (rail_en_out[2] |-> pg[0] && bpg)
      else $error("positive source enabled without negative good"); // RQ8
   ok_pin_a: assert property (rail_en_out != 4'hF |-> rails_ok_oe_out)
      else $error("ok pin released with a rail off"); // RQ16
   fault_pd_a: assert property (r.mode == dsq_pkg::M_ACTIVE && gfault
      |=> r.mode == dsq_pkg::M_PWRDN && r.tgt == dsq_pkg::M_STANDBY)
      else $error("global fault not shutting down"); // RQ13
   wake_pd_a: assert property (r.mode == dsq_pkg::M_ACTIVE && !wake
      |=> r.mode == dsq_pkg::M_PWRDN)
      else $error("wake low not shutting down"); // RQ5
   sel_rise_a: assert property (r.mode == dsq_pkg::M_STANDBY && wake && !gfault
      && rise[0] |=> r.mode == dsq_pkg::M_ACTIVE && r.req[0])
      else $error("select rise not taken"); // RQ1
   dual_fall_a: assert property (r.mode == dsq_pkg::M_ACTIVE && !gfault
      && $countones(fall) > 1 |=> r.req == 4'h0)
      else $error("joint fall left rails requested"); // RQ11
   sleep_off_a: assert property (r.mode == dsq_pkg::M_SLEEP
      |-> !inverter_en_out && rail_en_out == 4'h0)
      else $error("rail enabled in sleep"); // RQ20
   uv_drop_a: assert property (r.mode == dsq_pkg::M_ACTIVE && !gfault && wake
      && uv[0] && en[0] |=> !r.req[0] && !r.req[2])
      else $error("rail undervoltage kept rail"); // RQ14
endmodule : dsq_seq

// ===== dsq_rail_model.sv
// Purpose: converters and thermistor adc that answer the sequencer
// Assumes: power-good settles PG_DLY cycles after its enable
// Notes:   stuck_in keeps the inverter from ever regulating
module dsq_rail_model #(
   parameter int PG_DLY = 8
) (
   // clock and stimulus
   input  wire logic       clk_in,
   input  wire logic       stuck_in,
   input  wire logic [9:0] adc_val_in,
   // enables from the sequencer
   input  wire logic       boost_en_in,
   input  wire logic       inv_en_in,
   input  wire logic [3:0] rail_en_in,
   input  wire logic       adc_start_in,
   // status back to the sequencer
   output logic            boost_pg_out,
   output logic            inv_pg_out,
   output logic [3:0]      rail_pg_out,
   output logic            adc_done_out,
   output logic [9:0]      adc_raw_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int         cnt [6] = '{default: 0};
   logic [5:0] en;
   logic [5:0] pg;
   logic [2:0] sh = 3'h0;
   // =======================================================
   // settle counters; pg drops with its enable at once
   assign en = {inv_en_in & ~stuck_in, boost_en_in, rail_en_in};
   always @(posedge clk_in) begin
      for (int i = 0; i < 6; i++) begin
         cnt[i] <= !en[i] ? 0 : (cnt[i] < PG_DLY) ? cnt[i] + 1 : cnt[i];
      end
      sh <= {sh[1:0], adc_start_in};
   end
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pg[i] = en[i] && (cnt[i] == PG_DLY);
      end
   end
   assign {inv_pg_out, boost_pg_out, rail_pg_out} = pg;
   // raw is junk outside the done cycle, so a late sample shows up
   assign adc_done_out = sh[2];
   assign adc_raw_out  = sh[2] ? adc_val_in : ~adc_val_in;
endmodule : dsq_rail_model

// ===== tb_top.sv
// Purpose: self-checking bench for the rail sequencer
// Assumes: short parameters stand in for the long counts
// Notes:   host pins change by non-blocking assignment after edges
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RD  = 20;
   localparam int GAP = 1300;
   localparam int IVL = 200;
   logic       sys_clk_in = 0;
   logic       reset_in = 1;
   logic [3:0] sel = 4'h0;
   logic       wake = 0;
   logic [3:0] uv = 4'h0;
   logic       trip = 0;
   logic       stuck = 0;
   logic [9:0] adc_val = 10'h062;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 0;
   logic       rd = 0;
   logic       bpg, ipg, boost_en, inv_en, bias_en, ok, ok_oe, start, done;
   logic [3:0] rpg, en;
   logic [9:0] raw;
   logic [7:0] rdata, code;
   logic [9:0] raw_tab [6] = '{10'h062, 10'h049, 10'h06C, 10'h0C8, 10'h00D, 10'h000};
   logic [7:0] code_tab [6] = '{8'h00, 8'h19, 8'hF6, 8'hF6, 8'h55, 8'h55};
   int         n_mismatch = 0;
   int         comparisons = 0;
   // =======================================================
   // design and its analog far side
   dsq_seq #(.RAIL_DLY(RD), .BASE_TMO(60), .TEMP_IVL(IVL)) dsq_seq_inst (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .rail_select_in(sel),
      .wake_request_in(wake), .boost_pg_in(bpg), .inverter_pg_in(ipg), .rail_pg_in(rpg),
      .rail_uv_in(uv), .thermal_trip_in(trip), .input_supply_lockout_in(1'b0),
      .boost_undervoltage_in(1'b0), .inverter_undervoltage_in(1'b0),
      .boost_en_out(boost_en), .inverter_en_out(inv_en), .rail_en_out(en),
      .backplane_bias_en_out(bias_en), .rails_ok_out(ok), .rails_ok_oe_out(ok_oe),
      .adc_start_out(start), .adc_done_in(done), .adc_raw_in(raw),
      .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd),
      .bus_rdata_out(rdata), .temperature_code_out(code));
   dsq_rail_model dsq_rail_model_inst (
      .clk_in(sys_clk_in), .stuck_in(stuck), .adc_val_in(adc_val),
      .boost_en_in(boost_en), .inv_en_in(inv_en), .rail_en_in(en), .adc_start_in(start),
      .boost_pg_out(bpg), .inv_pg_out(ipg), .rail_pg_out(rpg), .adc_done_out(done),
      .adc_raw_out(raw));
   initial begin
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   // =======================================================
   // shared tasks
   task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : tick
   task automatic pins(input logic [3:0] s, input logic w);
      @(posedge sys_clk_in);
      sel <= s;
      wake <= w;
   endtask : pins
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_in);
      wr <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_in);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd
   task automatic mode_is(input logic [1:0] m);
      logic [7:0] d;
      bus_rd(dsq_pkg::REG_STAT, d);
      check("mode", 8'(d[1:0]), 8'(m));
   endtask : mode_is
   // bounded wait, then the exact enable vector must show
   task automatic wait_en(input logic [3:0] e);
      for (int i = 0; i < 200 && en !== e; i++) tick(1);
      check("rail_en", 8'(en), 8'(e));
   endtask : wait_en
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   // =======================================================
   // watchdog, well past the expected run length
   initial begin
      #(40000 * 50);
      n_mismatch++;
      stop_test();
   end
   // =======================================================
   // main sequence
   initial begin
      logic [7:0] d;
      int i;
      tick(3);
      reset_in <= 1'b0;
      bus_wr(4'hF, 8'h5A);
      bus_rd(dsq_pkg::REG_RAILS, d);
      check("rails", d, 8'h00);
      mode_is(2'd0);
      pins(4'h0, 1'b1);
      tick(10);
      mode_is(2'd1);
      // host-ordered power-up, each rise well apart
      pins(4'h1, 1'b1);
      tick(5);
      check("inv_en", 8'(inv_en), 8'h01);
      check("boost_en", 8'(boost_en), 8'h00);
      check("rail_en", 8'(en), 8'h00);
      wait_en(4'h1);
      check("bias_en", 8'(bias_en), 8'h01);
      for (i = 1; i < 4; i++) begin
         tick(GAP);
         pins(4'((2 << i) - 1), 1'b1);
         wait_en(4'((2 << i) - 1));
      end
      tick(20);
      check("ok_oe", 8'(ok_oe), 8'h00);
      check("ok", 8'(ok), 8'h00);
      // single rail fault drops it and its dependent
      uv <= 4'h1;
      wait_en(4'hA);
      check("ok_oe", 8'(ok_oe), 8'h01);
      check("boost_en", 8'(boost_en), 8'h01);
      uv <= 4'h0;
      tick(40);
      check("rail_en", 8'(en), 8'h0A);
      pins(4'hE, 1'b1);
      tick(GAP);
      pins(4'hF, 1'b1);
      wait_en(4'hB);
      tick(GAP);
      pins(4'hB, 1'b1);
      tick(GAP);
      pins(4'hF, 1'b1);
      wait_en(4'hF);
      tick(GAP);
      pins(4'h7, 1'b1);
      wait_en(4'h7);
      tick(GAP);
      pins(4'h4, 1'b1);
      wait_en(4'h0);
      tick(10);
      mode_is(2'd1);
      pins(4'h0, 1'b1);
      // close rises stagger in fixed order
      tick(GAP);
      pins(4'hF, 1'b1);
      wait_en(4'h1);
      wait_en(4'h3);
      wait_en(4'h7);
      wait_en(4'hF);
      // wake low mid-run: fixed power-down, then sleep
      pins(4'hF, 1'b0);
      tick(RD + 8);
      check("rail_en", 8'(en), 8'h07);
      tick(3 * RD + 20);
      check("rail_en", 8'(en), 8'h00);
      check("inv_en", 8'(inv_en), 8'h00);
      mode_is(2'd0);
      pins(4'hF, 1'b1);
      wait_en(4'hF);
      // global fault ends in standby
      tick(20);
      trip <= 1'b1;
      tick(6);
      check("ok_oe", 8'(ok_oe), 8'h01);
      tick(4 * RD + 20);
      check("rail_en", 8'(en), 8'h00);
      mode_is(2'd1);
      trip <= 1'b0;
      // inverter never regulates
      stuck <= 1'b1;
      pins(4'h0, 1'b1);
      tick(10);
      pins(4'h1, 1'b1);
      tick(60 + 4 * RD + 30);
      check("inv_en", 8'(inv_en), 8'h00);
      mode_is(2'd1);
      stuck <= 1'b0;
      // temperature codes, boundaries and saturation
      for (i = 0; i < 6; i++) begin
         adc_val <= raw_tab[i];
         bus_wr(dsq_pkg::REG_CTRL, 8'h03);
         tick(10);
         bus_rd(dsq_pkg::REG_TEMP, d);
         check("temp", d, code_tab[i]);
         check("temp_pin", code, code_tab[i]);
      end
      bus_wr(dsq_pkg::REG_TEMP, 8'hAA);
      bus_rd(dsq_pkg::REG_TEMP, d);
      check("temp_ro", d, 8'h55);
      // automatic refresh spacing
      for (i = 0; i < IVL + 50 && start !== 1'b1; i++) tick(1);
      tick(1);
      for (i = 1; i < IVL + 50 && start !== 1'b1; i++) tick(1);
      check("interval", 8'(i >= IVL - 1 && i <= IVL + 1), 8'h01);
      stop_test();
   end
endmodule : tb_top
